/* File: rtl/vmbd_cfg.svh */
// Constants of the VMEbus master block-DMA host controller
`ifndef VMBD_CFG_SVH
`define VMBD_CFG_SVH

// ****************************************************************
// Device register offsets, byte lane 0 except KICK, which is written through the window on all four lanes
// ****************************************************************
`define VMBD_DEV_ARB 32'h0000_00b0
`define VMBD_DEV_AMS 32'h0000_00b4
`define VMBD_DEV_BERR 32'h0000_00b8
`define VMBD_DEV_DMAST 32'h0000_00bc
`define VMBD_DEV_SS0C0 32'h0000_00c0
`define VMBD_DEV_SS0C1 32'h0000_00c4
`define VMBD_DEV_SS1C0 32'h0000_00c8
`define VMBD_DEV_SS1C1 32'h0000_00cc
`define VMBD_DEV_REL 32'h0000_00d0
`define VMBD_DEV_BTDEF 32'h0000_00d4
`define VMBD_DEV_BTCTL 32'h0000_00d8
`define VMBD_DEV_LEN0 32'h0000_00dc
`define VMBD_DEV_LEN1 32'h0000_00e0
`define VMBD_DEV_KICK 32'h0000_00f0
`define VMBD_BE_REG 4'h1
`define VMBD_BE_ALL 4'hf

// ****************************************************************
// Fixed device register values and fields
// ****************************************************************
`define VMBD_ARB_REFRESH 4
`define VMBD_SS0C0_BASE 8'h16
`define VMBD_SS1C0_BASE 8'h12
`define VMBD_SS_SUPER 5
`define VMBD_SS_LBTIME 8'h00
`define VMBD_BTDEF_BASE 8'h4d
`define VMBD_BTDEF_D64 4
`define VMBD_BTDEF_X2K 7
`define VMBD_BTCTL_ILV 8'h0f
`define VMBD_BTCTL_DIR 4
`define VMBD_BTCTL_EN 6
`define VMBD_DMAST_CLR 8'h00

// ****************************************************************
// Host register map (addr_i is a word index)
// ****************************************************************
`define VMBD_H_CTRL 3'h0
`define VMBD_H_ARB 3'h1
`define VMBD_H_REL 3'h2
`define VMBD_H_LEN 3'h3
`define VMBD_H_START 3'h4
`define VMBD_H_STAT 3'h5
`define VMBD_H_SADDR 3'h6
`define VMBD_H_SDATA 3'h7
`define VMBD_C_GO 0
`define VMBD_C_DIR 1
`define VMBD_C_D64 2
`define VMBD_C_X2K 3
`define VMBD_C_SGO 4
`define VMBD_C_SWR 5
`define VMBD_C_SUP 6
`define VMBD_C_BE 11:8
`define VMBD_S_DONE 1
`define VMBD_S_FAULT 2
`define VMBD_S_SDONE 3
`define VMBD_ALIGN_2K 11

`endif

/* File: rtl/vmbd_pkg.sv */
// Types shared by the VMEbus master block-DMA host controller
`default_nettype none
package vmbd_pkg;
    typedef struct packed {
        logic win;
        logic wr;
        logic [31:0] addr;
        logic [31:0] data;
        logic [3:0] be;
    } vmbd_req_s;
endpackage : vmbd_pkg
`default_nettype wire

/* File: rtl/vmbd_dev_port.sv */
// One access at a time toward the device port, held until acknowledged
`default_nettype none
module vmbd_dev_port #(
    parameter int DATA_W = 32
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic go_i,
    input wire vmbd_pkg::vmbd_req_s req_i,
    output logic done_o,
    output logic [31:0] rdata_o,
    output vmbd_pkg::vmbd_req_s dev_o,
    output logic dev_wr_o,
    output logic dev_rd_o,
    input wire logic dev_ack_i,
    input wire logic [31:0] dev_rdata_i
);
    if (DATA_W != 32) begin : g_bad_width
        $error("vmbd_dev_port serves 32-bit data only");
    end

    vmbd_pkg::vmbd_req_s next_dev;
    logic next_wr;
    logic next_rd;
    logic next_done;
    logic [31:0] next_rdata;

    always_comb begin
        next_dev = dev_o;
        next_wr = dev_wr_o;
        next_rd = dev_rd_o;
        next_done = 1'b0;
        next_rdata = rdata_o;
        if (dev_wr_o || dev_rd_o) begin
            // Strobe holds until the device answers; no timeout here
            if (dev_ack_i) begin
                next_wr = 1'b0;
                next_rd = 1'b0;
                next_done = 1'b1;
                next_rdata = dev_rdata_i;
            end
        end else if (go_i) begin
            next_dev = req_i;
            next_wr = req_i.wr;
            next_rd = ~req_i.wr;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dev_o <= '0;
            dev_wr_o <= 1'b0;
            dev_rd_o <= 1'b0;
            done_o <= 1'b0;
            rdata_o <= 32'h0000_0000;
        end else begin
            dev_o <= next_dev;
            dev_wr_o <= next_wr;
            dev_rd_o <= next_rd;
            done_o <= next_done;
            rdata_o <= next_rdata;
        end
    end
endmodule : vmbd_dev_port
`default_nettype wire

/* File: rtl/vmbd_host.sv */
// Host controller that configures the VME interface and runs block DMA
`include "vmbd_cfg.svh"
`default_nettype none

module vmbd_host (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [2:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic busy_o,
    output logic [31:0] dev_addr_o,
    output logic [31:0] dev_wdata_o,
    output logic [3:0] dev_be_o,
    output logic dev_win_o,
    output logic dev_wr_o,
    output logic dev_rd_o,
    input wire logic dev_ack_i,
    input wire logic [31:0] dev_rdata_i,
    input wire logic dev_irq_i
);
    typedef enum {
        ST_IDLE, ST_ARB, ST_AMS, ST_SS0C0, ST_SS0C1, ST_SS1C0, ST_SS1C1, ST_REL,
        ST_BTDEF, ST_LEN0, ST_LEN1, ST_BTEN, ST_KICK, ST_BTOFF, ST_WAIT,
        ST_RDST, ST_RDBERR, ST_CLRST, ST_CLRBERR, ST_SINGLE
    } vmbd_state_e;

    // ****************************************************************
    // Host registers and sequencer state
    // ****************************************************************
    vmbd_state_e state, next_state;
    logic [7:0] ctrl, next_ctrl;
    logic [15:0] arb_cfg, next_arb_cfg;
    logic [7:0] rel_cfg, next_rel_cfg;
    logic [15:0] len, next_len;
    logic [31:0] start_addr, next_start_addr;
    logic [31:0] s_addr, next_s_addr;
    logic [31:0] s_data, next_s_data;
    logic [3:0] s_be, next_s_be;
    logic [7:0] dma_st, next_dma_st;
    logic [7:0] berr_st, next_berr_st;
    logic done, next_done, fault, next_fault, s_done, next_s_done;
    logic [31:0] next_rdata, port_rdata;
    logic next_busy, port_go, port_done, go_ok;
    vmbd_pkg::vmbd_req_s req, dev_req;
    logic irq_s1, irq_s2, irq_s3, irq, next_irq;

    function automatic vmbd_pkg::vmbd_req_s reg_wr(input logic [31:0] ofs,
                                                   input logic [7:0] val);
        vmbd_pkg::vmbd_req_s r;
        r.win = 1'b0;
        r.wr = 1'b1;
        r.addr = ofs;
        r.data = {24'h00_0000, val};
        r.be = `VMBD_BE_REG;
        return r;
    endfunction : reg_wr

    function automatic vmbd_pkg::vmbd_req_s reg_rd(input logic [31:0] ofs);
        vmbd_pkg::vmbd_req_s r;
        r = reg_wr(ofs, 8'h00);
        r.wr = 1'b0;
        return r;
    endfunction : reg_rd

    // ****************************************************************
    // Device access for the current step
    // ****************************************************************
    always_comb begin
        logic [7:0] v;
        v = 8'h00;
        req = reg_rd(`VMBD_DEV_DMAST);
        unique case (state)
            ST_IDLE, ST_WAIT: req = reg_rd(`VMBD_DEV_DMAST);
            ST_ARB: begin
                v = arb_cfg[7:0];
                v[`VMBD_ARB_REFRESH] = 1'b0;
                req = reg_wr(`VMBD_DEV_ARB, v);
            end
            ST_AMS: req = reg_wr(`VMBD_DEV_AMS, arb_cfg[15:8]);
            ST_SS0C0, ST_SS1C0: begin
                v = (state == ST_SS0C0) ? `VMBD_SS0C0_BASE : `VMBD_SS1C0_BASE;
                v[`VMBD_SS_SUPER] = ctrl[`VMBD_C_SUP];
                req = reg_wr((state == ST_SS0C0) ? `VMBD_DEV_SS0C0 : `VMBD_DEV_SS1C0, v);
            end
            ST_SS0C1: req = reg_wr(`VMBD_DEV_SS0C1, `VMBD_SS_LBTIME);
            ST_SS1C1: req = reg_wr(`VMBD_DEV_SS1C1, `VMBD_SS_LBTIME);
            ST_REL: req = reg_wr(`VMBD_DEV_REL, rel_cfg);
            ST_BTDEF: begin
                v = `VMBD_BTDEF_BASE;
                v[`VMBD_BTDEF_D64] = ctrl[`VMBD_C_D64];
                v[`VMBD_BTDEF_X2K] = ctrl[`VMBD_C_X2K];
                req = reg_wr(`VMBD_DEV_BTDEF, v);
            end
            ST_LEN0: req = reg_wr(`VMBD_DEV_LEN0, len[7:0]);
            ST_LEN1: req = reg_wr(`VMBD_DEV_LEN1, len[15:8]);
            ST_BTEN, ST_BTOFF: begin
                v = `VMBD_BTCTL_ILV;
                v[`VMBD_BTCTL_DIR] = ctrl[`VMBD_C_DIR];
                v[`VMBD_BTCTL_EN] = (state == ST_BTEN);
                req = reg_wr(`VMBD_DEV_BTCTL, v);
            end
            ST_KICK: begin
                req = reg_wr(`VMBD_DEV_KICK, 8'h00);
                req.win = 1'b1;
                req.data = start_addr;
                req.be = `VMBD_BE_ALL;
            end
            ST_RDST: req = reg_rd(`VMBD_DEV_DMAST);
            ST_RDBERR: req = reg_rd(`VMBD_DEV_BERR);
            ST_CLRST: req = reg_wr(`VMBD_DEV_DMAST, `VMBD_DMAST_CLR);
            ST_CLRBERR: req = reg_wr(`VMBD_DEV_BERR, berr_st);
            ST_SINGLE: begin
                req.win = 1'b1;
                req.wr = ctrl[`VMBD_C_SWR];
                req.addr = s_addr;
                req.data = s_data;
                req.be = s_be;
            end
        endcase
    end

    // ****************************************************************
    // Sequencer, host register file and read port
    // ****************************************************************
    always_comb begin
        // 64 KB limit follows from the 16-bit count; zero and odd are refused
        go_ok = (len != 16'h0000) && !len[0];
        if (wdata_i[`VMBD_C_D64] && wdata_i[`VMBD_C_X2K]
            && (start_addr[`VMBD_ALIGN_2K-1:0] != '0)) begin
            go_ok = 1'b0;
        end
        next_state = state;
        next_ctrl = ctrl;
        next_arb_cfg = arb_cfg;
        next_rel_cfg = rel_cfg;
        next_len = len;
        next_start_addr = start_addr;
        next_s_addr = s_addr;
        next_s_data = s_data;
        next_s_be = s_be;
        next_dma_st = dma_st;
        next_berr_st = berr_st;
        next_done = done;
        next_fault = fault;
        next_s_done = s_done;
        next_rdata = 32'h0000_0000;
        port_go = 1'b0;
        unique case (state)
            ST_IDLE: ;
            ST_WAIT: begin
                if (irq) begin
                    next_state = ST_RDST;
                end
            end
            default: begin
                port_go = 1'b1;
                if (port_done) begin
                    port_go = 1'b0;
                    unique case (state)
                        ST_BTOFF: next_state = ST_WAIT;
                        ST_RDST: begin
                            next_dma_st = port_rdata[7:0];
                            next_state = ST_RDBERR;
                        end
                        ST_RDBERR: begin
                            next_berr_st = port_rdata[7:0];
                            next_state = ST_CLRST;
                        end
                        ST_CLRBERR: begin
                            next_done = 1'b1;
                            next_state = ST_IDLE;
                        end
                        ST_SINGLE: begin
                            if (!ctrl[`VMBD_C_SWR]) begin
                                next_s_data = port_rdata;
                            end
                            next_s_done = 1'b1;
                            next_state = ST_IDLE;
                        end
                        default: next_state = vmbd_state_e'(state + 1);
                    endcase
                end
            end
        endcase
        if (rd_i) begin
            unique case (addr_i)
                `VMBD_H_CTRL: next_rdata = {24'h00_0000, ctrl};
                `VMBD_H_ARB: next_rdata = {16'h0000, arb_cfg};
                `VMBD_H_REL: next_rdata = {24'h00_0000, rel_cfg};
                `VMBD_H_LEN: next_rdata = {16'h0000, len};
                `VMBD_H_START: next_rdata = start_addr;
                `VMBD_H_STAT: next_rdata = {8'h00, berr_st, dma_st, 4'h0,
                                            s_done, fault, done, busy_o};
                `VMBD_H_SADDR: next_rdata = s_addr;
                `VMBD_H_SDATA: next_rdata = {s_be, 28'h000_0000} | s_data;
            endcase
        end
        if (wr_i && (state == ST_IDLE)) begin
            // Writes during a run are dropped so a transfer sees stable setup
            unique case (addr_i)
                `VMBD_H_CTRL: begin
                    next_ctrl = wdata_i[7:0];
                    if (wdata_i[`VMBD_C_GO]) begin
                        if (go_ok) begin
                            next_state = ST_ARB;
                        end else begin
                            next_fault = 1'b1;
                        end
                    end else if (wdata_i[`VMBD_C_SGO]) begin
                        next_s_be = wdata_i[`VMBD_C_BE];
                        next_state = ST_SINGLE;
                    end
                end
                `VMBD_H_ARB: next_arb_cfg = wdata_i[15:0];
                `VMBD_H_REL: next_rel_cfg = wdata_i[7:0];
                `VMBD_H_LEN: next_len = wdata_i[15:0];
                `VMBD_H_START: next_start_addr = wdata_i;
                `VMBD_H_STAT: begin
                    // A flag set in this same cycle survives the clear
                    if (wdata_i[`VMBD_S_DONE] && (next_done == done)) next_done = 1'b0;
                    if (wdata_i[`VMBD_S_FAULT] && (next_fault == fault)) next_fault = 1'b0;
                    if (wdata_i[`VMBD_S_SDONE] && (next_s_done == s_done)) begin
                        next_s_done = 1'b0;
                    end
                end
                `VMBD_H_SADDR: next_s_addr = wdata_i;
                `VMBD_H_SDATA: next_s_data = wdata_i;
            endcase
        end
        next_busy = (next_state != ST_IDLE);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= ST_IDLE;
            ctrl <= 8'h00;
            arb_cfg <= 16'h0000;
            rel_cfg <= 8'h00;
            len <= 16'h0000;
            start_addr <= 32'h0000_0000;
            s_addr <= 32'h0000_0000;
            s_data <= 32'h0000_0000;
            s_be <= 4'h0;
            dma_st <= 8'h00;
            berr_st <= 8'h00;
            done <= 1'b0;
            fault <= 1'b0;
            s_done <= 1'b0;
            rdata_o <= 32'h0000_0000;
            busy_o <= 1'b0;
        end else begin
            state <= next_state;
            ctrl <= next_ctrl;
            arb_cfg <= next_arb_cfg;
            rel_cfg <= next_rel_cfg;
            len <= next_len;
            start_addr <= next_start_addr;
            s_addr <= next_s_addr;
            s_data <= next_s_data;
            s_be <= next_s_be;
            dma_st <= next_dma_st;
            berr_st <= next_berr_st;
            done <= next_done;
            fault <= next_fault;
            s_done <= next_s_done;
            rdata_o <= next_rdata;
            busy_o <= next_busy;
        end
    end

    // ****************************************************************
    // Completion pin: three stages, change taken when last two agree
    // ****************************************************************
    always_comb begin
        next_irq = (irq_s2 == irq_s3) ? irq_s3 : irq;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_s1 <= 1'b0;
            irq_s2 <= 1'b0;
            irq_s3 <= 1'b0;
            irq <= 1'b0;
        end else begin
            irq_s1 <= dev_irq_i;
            irq_s2 <= irq_s1;
            irq_s3 <= irq_s2;
            irq <= next_irq;
        end
    end

    vmbd_dev_port #(.DATA_W(32)) u_port (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .go_i(port_go),
        .req_i(req),
        .done_o(port_done),
        .rdata_o(port_rdata),
        .dev_o(dev_req),
        .dev_wr_o(dev_wr_o),
        .dev_rd_o(dev_rd_o),
        .dev_ack_i(dev_ack_i),
        .dev_rdata_i(dev_rdata_i)
    );

    assign dev_addr_o = dev_req.addr;
    assign dev_wdata_o = dev_req.data;
    assign dev_be_o = dev_req.be;
    assign dev_win_o = dev_req.win;
endmodule : vmbd_host
`default_nettype wire

/* File: verification/vmbd_host_assertions.sv */
// Concurrent checks on the ports of the block-DMA host controller
`include "vmbd_cfg.svh"
`default_nettype none
module vmbd_host_chk (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [2:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic busy_o,
    input wire logic [31:0] dev_addr_o,
    input wire logic [31:0] dev_wdata_o,
    input wire logic [3:0] dev_be_o,
    input wire logic dev_win_o,
    input wire logic dev_wr_o,
    input wire logic dev_rd_o,
    input wire logic dev_ack_i,
    input wire logic [31:0] dev_rdata_i,
    input wire logic dev_irq_i
);
    timeunit 1ns / 1ns;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire logic strobe = dev_wr_o || dev_rd_o;
    wire logic reg_wr = dev_wr_o && !dev_win_o;
    sequence s_kick;
        dev_wr_o && dev_win_o && dev_ack_i && dev_addr_o == `VMBD_DEV_KICK;
    endsequence
    property p_hold;
        strobe && !dev_ack_i |=> strobe && $stable(dev_addr_o) && $stable(dev_wdata_o);
    endproperty
    property p_drop;
        strobe && dev_ack_i |=> !strobe;
    endproperty
    property p_arb;
        reg_wr && dev_addr_o == `VMBD_DEV_ARB |-> !dev_wdata_o[4];
    endproperty
    property p_ss0;
        reg_wr && dev_addr_o == `VMBD_DEV_SS0C0 |-> dev_wdata_o == 32'h16 || dev_wdata_o == 32'h36;
    endproperty
    property p_ss1;
        reg_wr && dev_addr_o == `VMBD_DEV_SS1C0 |-> dev_wdata_o == 32'h12 || dev_wdata_o == 32'h32;
    endproperty
    property p_timing;
        reg_wr && (dev_addr_o == `VMBD_DEV_SS0C1 || dev_addr_o == `VMBD_DEV_SS1C1)
            |-> dev_wdata_o == 32'h0;
    endproperty
    property p_btctl;
        reg_wr && dev_addr_o == `VMBD_DEV_BTCTL |-> dev_wdata_o[3:0] == 4'hf && !dev_wdata_o[5];
    endproperty
    property p_kick;
        s_kick |-> dev_be_o == 4'hf
            ##[1:8] reg_wr && dev_addr_o == `VMBD_DEV_BTCTL && !dev_wdata_o[6];
    endproperty
    property p_len;
        reg_wr && dev_ack_i && dev_addr_o == `VMBD_DEV_LEN0
            |-> ##[1:8] reg_wr && dev_addr_o == `VMBD_DEV_LEN1;
    endproperty
    property p_start;
        $rose(busy_o) |=> strobe && (dev_win_o || dev_addr_o == `VMBD_DEV_ARB);
    endproperty
    a_hold: assert property (p_hold) else $error("device strobe dropped early");
    a_drop: assert property (p_drop) else $error("strobe kept after answer");
    a_arb: assert property (p_arb) else $error("refresh bit written as one");
    a_ss0: assert property (p_ss0) else $error("slave select 0 value wrong");
    a_ss1: assert property (p_ss1) else $error("slave select 1 value wrong");
    a_timing: assert property (p_timing) else $error("bus timing not zero");
    a_btctl: assert property (p_btctl) else $error("transfer control value wrong");
    a_kick: assert property (p_kick) else $error("enable not cleared after start");
    a_len: assert property (p_len) else $error("length high byte missing");
    a_start: assert property (p_start) else $error("run did not begin with bus setup");
endmodule : vmbd_host_chk
bind vmbd_host vmbd_host_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .busy_o(busy_o),
    .dev_addr_o(dev_addr_o), .dev_wdata_o(dev_wdata_o), .dev_be_o(dev_be_o),
    .dev_win_o(dev_win_o), .dev_wr_o(dev_wr_o), .dev_rd_o(dev_rd_o), .dev_ack_i(dev_ack_i),
    .dev_rdata_i(dev_rdata_i), .dev_irq_i(dev_irq_i));
`default_nettype wire

/* File: verification/vmbd_dev_model.sv */
// Behavioural model of the VME interface device behind the host controller
`default_nettype none
module vmbd_dev_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [31:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] be_i,
    input wire logic win_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic slow_i,
    input wire logic err_i,
    output logic ack_o,
    output logic [31:0] rdata_o,
    output logic irq_o
);
    timeunit 1ns / 1ns;
    logic [7:0] regs [0:63];
    logic [7:0] dmast, berr;
    logic [3:0] be_seen;
    logic wr_seen, armed;
    logic [31:0] win_addr, win_data, last, value;
    logic [16:0] remain;
    logic [2:0] wait_cnt;
    assign ack_o = (wr_i || rd_i) && wait_cnt >= (slow_i ? 3'h3 : 3'h0);
    always_comb begin
        case (addr_i[7:0])
            8'hbc: value = {24'h0, dmast | 8'h60};
            8'hb8: value = {24'h0, berr};
            default: value = {24'h0, regs[addr_i[7:2]]};
        endcase
        if (win_i) value = 32'h0000_0abc;
    end
    // A released bus shows the inverse of the last answer, never a stale copy
    assign rdata_o = ack_o ? value : ~last;
    assign irq_o = remain == 17'h0 && dmast[0];
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_cnt <= 3'h0;
            dmast <= 8'h0;
            berr <= 8'h0;
            armed <= 1'b0;
            remain <= 17'h0;
            last <= 32'h0;
        end else begin
            wait_cnt <= (wr_i || rd_i) && !ack_o ? wait_cnt + 3'h1 : 3'h0;
            if (remain > 17'h2) remain <= remain - 17'h2;
            else if (remain == 17'h2) begin
                remain <= 17'h0;
                dmast <= dmast | (err_i ? 8'h14 : 8'h00);
                berr <= berr | (err_i ? 8'h05 : 8'h00);
            end
            if (ack_o) last <= value;
            if (ack_o && win_i) begin
                be_seen <= be_i;
                wr_seen <= wr_i;
                win_addr <= addr_i;
                win_data <= wdata_i;
                if (wr_i && addr_i[7:0] == 8'hf0 && regs[6'h36][6]) armed <= 1'b1;
            end else if (ack_o && wr_i) begin
                case (addr_i[7:0])
                    8'hbc: dmast <= dmast & wdata_i[7:0];
                    8'hb8: berr <= berr & ~wdata_i[7:0];
                    default: regs[addr_i[7:2]] <= wdata_i[7:0];
                endcase
                if (addr_i[7:0] == 8'hd8 && armed && !wdata_i[6]) begin
                    armed <= 1'b0;
                    dmast[0] <= 1'b1;
                    remain <= {1'b0, regs[6'h38], regs[6'h37]};
                end
            end
        end
    end
endmodule : vmbd_dev_model
`default_nettype wire

/* File: verification/vmbd_host_tb_top.sv */
// Self-checking testbench of the block-DMA host controller
`default_nettype none
module vmbd_host_tb_top;
    timeunit 1ns / 1ns;
    logic clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, slow = 1'b0, err = 1'b0;
    logic [2:0] addr_i = 3'h0;
    logic [31:0] wdata_i = 32'h0;
    logic [31:0] rdata_o, dev_addr_o, dev_wdata_o, dev_rdata_i;
    logic [3:0] dev_be_o;
    logic busy_o, dev_win_o, dev_wr_o, dev_rd_o, dev_ack_i, dev_irq_i;
    int fails = 0, n_checks = 0;
    always #50 clk_i = ~clk_i;
    vmbd_host uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .busy_o(busy_o), .dev_addr_o(dev_addr_o),
        .dev_wdata_o(dev_wdata_o), .dev_be_o(dev_be_o), .dev_win_o(dev_win_o),
        .dev_wr_o(dev_wr_o), .dev_rd_o(dev_rd_o), .dev_ack_i(dev_ack_i),
        .dev_rdata_i(dev_rdata_i), .dev_irq_i(dev_irq_i));
    vmbd_dev_model dev (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(dev_addr_o),
        .wdata_i(dev_wdata_o), .be_i(dev_be_o), .win_i(dev_win_o), .wr_i(dev_wr_o),
        .rd_i(dev_rd_o), .slow_i(slow), .err_i(err), .ack_o(dev_ack_i),
        .rdata_o(dev_rdata_i), .irq_o(dev_irq_i));
    // ****************************************************************
    // Bus tasks
    // ****************************************************************
    task automatic report_and_stop;
        if (fails == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic hw(input logic [2:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : hw
    task automatic hr(input logic [2:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        d = rdata_o;
    endtask : hr
    task automatic wait_idle;
        int n = 0;
        @(negedge clk_i);
        while (busy_o !== 1'b0 && n < 3000) begin
            @(negedge clk_i);
            n++;
        end
        if (n == 3000) begin
            fails++;
            report_and_stop();
        end
    endtask : wait_idle
    // Write run: refresh bit offered as one must reach the device as zero
    task automatic t_dma_write;
        logic [31:0] d;
        hw(3'h1, 32'h0000_a9ff);
        hw(3'h2, 32'h0000_00c5);
        hw(3'h3, 32'h0000_0100);
        hw(3'h4, 32'h1234_5678);
        hw(3'h0, 32'h0000_0045);
        wait_idle();
        chk(dev.regs[6'h2c], 32'hef);
        chk(dev.regs[6'h2d], 32'ha9);
        chk(dev.regs[6'h30], 32'h36);
        chk(dev.regs[6'h31] | dev.regs[6'h33], 32'h0);
        chk(dev.regs[6'h32], 32'h32);
        chk(dev.regs[6'h34], 32'hc5);
        chk(dev.regs[6'h35], 32'h5d);
        chk(dev.regs[6'h36], 32'h0f);
        chk({dev.regs[6'h38], dev.regs[6'h37]}, 32'h0100);
        chk(dev.win_data, 32'h1234_5678);
        chk(dev.dmast, 32'h0);
        hr(3'h5, d);
        chk(d, 32'h0000_6102);
    endtask : t_dma_write
    // Read run on a slow device that flags a bus error
    task automatic t_dma_read;
        logic [31:0] d;
        slow <= 1'b1;
        err <= 1'b1;
        hw(3'h5, 32'h0000_000e);
        hw(3'h3, 32'h0000_0040);
        hw(3'h0, 32'h0000_0003);
        wait_idle();
        chk(dev.regs[6'h36], 32'h1f);
        chk(dev.berr, 32'h0);
        chk(dev.dmast, 32'h0);
        hr(3'h5, d);
        chk(d, 32'h0005_7502);
        slow <= 1'b0;
        err <= 1'b0;
    endtask : t_dma_read
    // Zero, odd and unaligned 64-bit requests start nothing
    task automatic t_refuse;
        logic [31:0] d;
        logic [15:0] lens [3] = '{16'h0000, 16'h0003, 16'h0100};
        logic [31:0] sts [3] = '{32'h0, 32'h0, 32'h0000_0400};
        logic [7:0] ctl [3] = '{8'h01, 8'h01, 8'h0d};
        for (int i = 0; i < 3; i++) begin
            hw(3'h5, 32'h0000_000e);
            hw(3'h3, {16'h0, lens[i]});
            hw(3'h4, sts[i]);
            hw(3'h0, {24'h0, ctl[i]});
            @(negedge clk_i);
            chk({31'h0, busy_o}, 32'h0);
            hr(3'h5, d);
            chk({28'h0, d[3:0]}, 32'h4);
        end
    endtask : t_refuse
    // Single window transfers sized by byte enables
    task automatic t_single;
        logic [31:0] d;
        logic [3:0] bes [3] = '{4'h1, 4'h3, 4'hf};
        for (int i = 0; i < 3; i++) begin
            hw(3'h6, 32'h0040_0010 + i);
            hw(3'h7, 32'h0000_0055);
            hw(3'h0, {20'h0, bes[i], 8'h30});
            wait_idle();
            chk({dev.wr_seen, dev.be_seen}, {1'b1, bes[i]});
            chk(dev.win_addr ^ dev.win_data, (32'h0040_0010 + i) ^ 32'h55);
            hw(3'h0, {20'h0, bes[i], 8'h10});
            wait_idle();
            chk({dev.wr_seen, dev.be_seen}, {1'b0, bes[i]});
            hr(3'h7, d);
            chk(d, {bes[i], 28'h0000abc});
        end
    endtask : t_single
    initial begin
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(negedge clk_i);
        chk({rdata_o[0], busy_o, dev_wr_o, dev_rd_o}, 32'h0);
        t_dma_write();
        t_dma_read();
        t_refuse();
        t_single();
        report_and_stop();
    end
endmodule : vmbd_host_tb_top
`default_nettype wire
